// [src/luc_top.sv]
// Purpose: control, status and error registers of a LIN/UART controller
// Assumes: serial engine outside; events arrive as one-cycle pulses on ref_clk_i
// Notes: registers on AXI4-Lite at byte address 4 * index
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module luc_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic [luc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [luc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire luc_pkg::luc_evt_s evt_i,
    input wire logic engine_busy_i,
    input wire logic [5:0] header_id_i,
    input wire logic [7:0] rx_data_i,
    output luc_pkg::luc_cfg_s cfg_o,
    output logic protocol_version_select_o,
    output logic engine_reset_o,
    output logic cmd_strobe_o,
    output logic [2:0] command_field_o,
    output logic [7:0] tx_data_o,
    output logic tx_data_strobe_o,
    output logic rx_data_read_o,
    output logic irq_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        luc_pkg::luc_ctrl_s ctrl;
        logic [2:0] id_status;
        logic hdr;
        logic tx;
        logic rx;
        logic [3:0] irq_en;
        luc_pkg::luc_err_s err;
        luc_pkg::luc_phase_e phase;
        logic [1:0] rst_cnt;
        logic aw_full;
        logic [luc_pkg::ADDR_W-1:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic cmd_strobe;
        logic [7:0] tx_data;
        logic tx_strobe;
        logic rd_strobe;
    } luc_state_s;

    luc_state_s st;
    luc_state_s next_st;
    luc_pkg::luc_ctrl_s wr_ctrl;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] word_index(input logic [luc_pkg::ADDR_W-1:0] a);
        word_index = a[9:2];
    endfunction

    function automatic logic [2:0] special_id(input logic [5:0] id);
        special_id = (id[5:2] == 4'hF) ? {1'b1, id[1:0]} : 3'h0;
    endfunction

    function automatic logic mapped(input logic [luc_pkg::ADDR_W-1:0] a);
        logic [7:0] i;
        i = word_index(a);
        mapped = (a[luc_pkg::ADDR_W-1:10] == '0) &&
            ((i == luc_pkg::IDX_CONTROL) || (i == luc_pkg::IDX_STATUS) ||
             (i == luc_pkg::IDX_IRQ_EN) || (i == luc_pkg::IDX_ERRORS) ||
             (i == luc_pkg::IDX_DATA));
    endfunction

    luc_cfg_decode u_decode (
        .ctrl_i(st.ctrl),
        .cfg_o(cfg_o)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic wr_go;
        logic rd_go;
        logic [7:0] widx;
        logic [7:0] ridx;
        logic [7:0] wb;
        logic wr_lane;
        logic err_clr;
        logic in_uart;
        logic [7:0] rb;
        logic cmd_ok;
        logic swres_req;
        wr_go = 1'b0;
        rd_go = 1'b0;
        widx = 8'h00;
        ridx = 8'h00;
        wb = 8'h00;
        wr_lane = 1'b0;
        err_clr = 1'b0;
        in_uart = st.ctrl.cmd[2];
        rb = 8'h00;
        cmd_ok = 1'b0;
        swres_req = 1'b0;
        wr_ctrl = st.ctrl;
        next_st = st;
        next_st.cmd_strobe = 1'b0;
        next_st.tx_strobe = 1'b0;
        next_st.rd_strobe = 1'b0;

        // ------------------------------------------------------------
        // bus channel capture
        // ------------------------------------------------------------
        if (s_axi_awvalid && !st.aw_full) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_full) begin
            next_st.w_full = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        wr_go = st.aw_full && st.w_full && !st.bvalid;
        rd_go = s_axi_arvalid && !st.rvalid;
        widx = word_index(st.aw_addr);
        ridx = word_index(s_axi_araddr);
        wb = st.w_data[7:0];
        wr_lane = st.w_strb[0];

        // ------------------------------------------------------------
        // register write
        // ------------------------------------------------------------
        if (wr_go) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = mapped(st.aw_addr) ? luc_pkg::AXI_OKAY : luc_pkg::AXI_SLVERR;
            // only byte lane 0 carries register data
            if (mapped(st.aw_addr) && wr_lane) begin
                case (widx)
                    luc_pkg::IDX_CONTROL: begin
                        wr_ctrl = wb;
                        next_st.ctrl.ver13 = wb[luc_pkg::CTRL_VER];
                        next_st.ctrl.conf = wr_ctrl.conf;
                        next_st.ctrl.enable = wr_ctrl.enable;
                        if (wr_ctrl.sw_reset) begin
                            next_st.ctrl.sw_reset = 1'b1;
                            swres_req = 1'b1;
                        end
                        // no command starts alongside a soft reset
                        cmd_ok = wr_ctrl.enable && !wr_ctrl.sw_reset &&
                            (st.phase != luc_pkg::LUC_RESET);
                        if (cmd_ok) begin
                            next_st.ctrl.cmd = wr_ctrl.cmd;
                            next_st.cmd_strobe = 1'b1;
                            if (engine_busy_i && wr_ctrl.cmd != luc_pkg::CMD_RX_HDR) begin
                                next_st.err.overrun_flag = 1'b1;
                            end
                            if (engine_busy_i && wr_ctrl.cmd == luc_pkg::CMD_RX_HDR) begin
                                next_st.err.abort_warning_flag = 1'b1;
                            end
                        end
                    end
                    luc_pkg::IDX_STATUS: begin
                        if (wb[luc_pkg::ST_ERR]) begin
                            err_clr = 1'b1;
                        end
                        if (wb[luc_pkg::ST_HDR]) begin
                            next_st.hdr = 1'b0;
                        end
                        if (wb[luc_pkg::ST_TX]) begin
                            next_st.tx = 1'b0;
                        end
                        if (wb[luc_pkg::ST_RX]) begin
                            next_st.rx = 1'b0;
                        end
                    end
                    luc_pkg::IDX_IRQ_EN: begin
                        next_st.irq_en = wb[3:0];
                    end
                    luc_pkg::IDX_DATA: begin
                        next_st.tx_data = wb;
                        next_st.tx_strobe = 1'b1;
                        if (in_uart) begin
                            next_st.tx = 1'b0;
                            next_st.rx = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        // ------------------------------------------------------------
        // read path
        // ------------------------------------------------------------
        if (rd_go) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = mapped(s_axi_araddr) ? luc_pkg::AXI_OKAY : luc_pkg::AXI_SLVERR;
            case (ridx)
                luc_pkg::IDX_CONTROL: rb = st.ctrl;
                luc_pkg::IDX_STATUS: begin
                    rb = {st.id_status, engine_busy_i, |st.err, st.hdr, st.tx, st.rx};
                end
                luc_pkg::IDX_IRQ_EN: rb = {4'h0, st.irq_en};
                luc_pkg::IDX_ERRORS: rb = st.err;
                luc_pkg::IDX_DATA: begin
                    rb = rx_data_i;
                    next_st.rd_strobe = 1'b1;
                    if (in_uart) begin
                        err_clr = 1'b1;
                    end
                end
                default: rb = 8'h00;
            endcase
            if (!mapped(s_axi_araddr)) begin
                rb = 8'h00;
            end
            next_st.rdata = {24'h000000, rb};
        end

        // ------------------------------------------------------------
        // flag updates
        // ------------------------------------------------------------
        if (err_clr) begin
            // flags raised by a command in this cycle survive the clear
            next_st.err = next_st.err & ~st.err;
        end
        // engine events win over a same-cycle clear
        next_st.err = next_st.err | evt_i.errs;
        if (in_uart && evt_i.byte_overwrite) begin
            next_st.err.overrun_flag = 1'b1;
        end
        if (evt_i.header_done) begin
            next_st.hdr = 1'b1;
            next_st.id_status = special_id(header_id_i);
        end
        if (evt_i.tx_done) begin
            next_st.tx = 1'b1;
        end
        if (evt_i.rx_done) begin
            next_st.rx = 1'b1;
        end
        if (|evt_i.errs && !in_uart) begin
            next_st.ctrl.cmd = luc_pkg::CMD_RX_HDR;
        end

        // ------------------------------------------------------------
        // soft reset sequencer
        // ------------------------------------------------------------
        case (st.phase)
            luc_pkg::LUC_IDLE: begin
                if (next_st.ctrl.sw_reset) begin
                    next_st.phase = luc_pkg::LUC_RESET;
                    next_st.rst_cnt = 2'(luc_pkg::SWRES_CYCLES);
                end
            end
            luc_pkg::LUC_RESET: begin
                next_st.ctrl = luc_pkg::CTRL_RESET;
                next_st.ctrl.sw_reset = 1'b1;
                next_st.hdr = 1'b0;
                next_st.tx = 1'b0;
                next_st.rx = 1'b0;
                next_st.err = '0;
                next_st.id_status = 3'h0;
                next_st.irq_en = 4'h0;
                next_st.rst_cnt = st.rst_cnt - 2'h1;
                if (st.rst_cnt == 2'h1) begin
                    next_st.phase = luc_pkg::LUC_RUN;
                end
            end
            luc_pkg::LUC_RUN: begin
                // a request written in this cycle restarts the sequence
                next_st.ctrl.sw_reset = swres_req;
                next_st.phase = luc_pkg::LUC_IDLE;
            end
            default: next_st.phase = luc_pkg::LUC_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else if (clk_en_i) begin
            // all state freezes while the clock enable is low
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // a write channel is ready while its capture register is empty; read address while no read data is pending
    assign s_axi_awready = !st.aw_full;
    assign s_axi_wready = !st.w_full;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign protocol_version_select_o = st.ctrl.ver13;
    // engine held in reset during a soft reset or while disabled
    assign engine_reset_o = (st.phase == luc_pkg::LUC_RESET) || !st.ctrl.enable;
    assign cmd_strobe_o = st.cmd_strobe;
    assign command_field_o = st.ctrl.cmd;
    assign tx_data_o = st.tx_data;
    assign tx_data_strobe_o = st.tx_strobe;
    assign rx_data_read_o = st.rd_strobe;
    assign irq_o = (st.irq_en[3] && |st.err) || (st.irq_en[2] && st.hdr) ||
        (st.irq_en[1] && st.tx) || (st.irq_en[0] && st.rx);
endmodule // luc_top
`default_nettype wire

// [src/luc_pkg.sv]
// Purpose: constants and carrier types of the link control/status block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: printed offsets are not multiples of four, so byte address = 4 * index
// Summary of operation
// - writing one to soft reset resets controller; bit self-clears when done
// - protocol version bit zero selects LIN 2.1, one selects LIN 1.3
// - LIN config field: standard, no checksum/timeout, no timeout, listen
// - UART config field: 8N1, even parity, odd parity, listen 8N1
// - enable bit turns controller on; commands act only while enabled
// - command 000 receive header/abort, 001 tx header, 010 rx, 011 tx response
// - top command bit selects UART; 100 off, 11x rx enable, 1x1 tx enable
// - special id status reads 0xx normally, 100..111 for identifiers 60..63
// - activity flag reads one while receiving or transmitting
// - error summary is OR of error flags; interrupts when enabled
// - writing one to error summary clears all error flags together
// - in UART mode reading the data register clears the error summary
// - header done set on id received or header sent; irq; write one clears
// - transmit done set on tx response end; irq; w1c; UART data write clears
// - receive done set on rx response end; irq; w1c; UART data write clears
// - interrupt enable holds error, header, transmit, receive bits 3..0, reset 0
// - error bits 6 timeout, 5 overrun, 4 framing, 3 sync; cleared with summary
// - bit 7 records abort command while busy; cleared with summary
// - error bits 2 id parity, 1 checksum, 0 bit error; cleared with summary
// - overrun on non-abort command while busy, or UART byte overwrite
// - after an error event from the engine in LIN mode the command field returns to 000
package luc_pkg;
    localparam logic [7:0] IDX_CONTROL = 8'hC8;
    localparam logic [7:0] IDX_STATUS = 8'hC9;
    localparam logic [7:0] IDX_IRQ_EN = 8'hCA;
    localparam logic [7:0] IDX_ERRORS = 8'hCB;
    localparam logic [7:0] IDX_DATA = 8'hD2;
    localparam logic [7:0] IDX_EVENTS = 8'hE0;
    localparam int ADDR_W = 12;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int CTRL_SWRES = 7;
    localparam int CTRL_VER = 6;
    localparam int CTRL_ENA = 3;
    localparam int ST_BUSY = 4;
    localparam int ST_ERR = 3;
    localparam int ST_HDR = 2;
    localparam int ST_TX = 1;
    localparam int ST_RX = 0;
    localparam logic [2:0] CMD_RX_HDR = 3'h0;
    localparam logic [2:0] CMD_TX_HDR = 3'h1;
    localparam logic [2:0] CMD_RX_RSP = 3'h2;
    localparam logic [2:0] CMD_TX_RSP = 3'h3;
    localparam logic [2:0] CMD_UART_OFF = 3'h4;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    localparam int SWRES_CYCLES = 2;
    typedef enum logic [1:0] {LUC_IDLE, LUC_RESET, LUC_RUN} luc_phase_e;
    typedef struct packed {
        logic sw_reset;
        logic ver13;
        logic [1:0] conf;
        logic enable;
        logic [2:0] cmd;
    } luc_ctrl_s;
    typedef struct packed {
        logic abort_warning_flag;
        logic frame_timeout_flag;
        logic overrun_flag;
        logic framing_flag;
        logic sync_fault_flag;
        logic id_parity_flag;
        logic checksum_fault_flag;
        logic bit_fault_flag;
    } luc_err_s;
    // events reported by the serial engine, one-cycle pulses
    typedef struct packed {
        logic header_done;
        logic tx_done;
        logic rx_done;
        logic byte_overwrite;
        luc_err_s errs;
    } luc_evt_s;
    // decoded configuration for the serial engine
    typedef struct packed {
        logic uart_mode;
        logic checksum_on;
        logic timeout_on;
        logic listen;
        logic parity_on;
        logic parity_odd;
        logic rx_enable;
        logic tx_enable;
    } luc_cfg_s;
endpackage

// [src/luc_cfg_decode.sv]
// Purpose: decode control fields into engine settings
// Assumes: pure combinational, same clock domain as caller
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module luc_cfg_decode (
    input wire luc_pkg::luc_ctrl_s ctrl_i,
    output luc_pkg::luc_cfg_s cfg_o
);
    always_comb begin
        cfg_o = '0;
        cfg_o.uart_mode = ctrl_i.cmd[2];
        if (ctrl_i.cmd[2]) begin
            cfg_o.parity_on = (ctrl_i.conf == 2'h1) || (ctrl_i.conf == 2'h2);
            cfg_o.parity_odd = (ctrl_i.conf == 2'h2);
            cfg_o.listen = (ctrl_i.conf == 2'h3);
            cfg_o.rx_enable = ctrl_i.enable && ctrl_i.cmd[1];
            cfg_o.tx_enable = ctrl_i.enable && ctrl_i.cmd[0];
        end else begin
            cfg_o.checksum_on = (ctrl_i.conf != 2'h1);
            cfg_o.timeout_on = (ctrl_i.conf == 2'h0) || (ctrl_i.conf == 2'h3);
            cfg_o.listen = (ctrl_i.conf == 2'h3);
        end
    end
endmodule // luc_cfg_decode
`default_nettype wire

// [testbench/luc_sva.sv]
// Purpose: port-level checks of luc_top
// Assumes: one clock, asynchronous active-low reset
// Notes: bound to luc_top below
`timescale 1ns/1ps
`default_nettype none
module luc_sva (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire luc_pkg::luc_evt_s evt_i,
    input wire luc_pkg::luc_cfg_s cfg_o,
    input wire logic engine_reset_o,
    input wire logic cmd_strobe_o,
    input wire logic [2:0] command_field_o,
    input wire logic irq_o,
    input wire logic tx_data_strobe_o,
    input wire logic rx_data_read_o
);
// ----------
// properties
// ----------
default clocking cb @(posedge ref_clk_i); endclocking
default disable iff (!rst_b_i);
a_err_withdraws_cmd: assert property (
    clk_en_i && evt_i.errs != 8'h00 && !cfg_o.uart_mode |=> command_field_o == 3'h0)
    else $error("command not withdrawn after error event");
a_lin_conf_legal: assert property (
    !cfg_o.uart_mode |-> (!cfg_o.listen || (cfg_o.checksum_on && cfg_o.timeout_on))
    && (cfg_o.checksum_on || !cfg_o.timeout_on)) else $error("bad lin configuration");
a_uart_format_legal: assert property (
    cfg_o.uart_mode |-> !(cfg_o.parity_on && cfg_o.listen) && (cfg_o.parity_on || !cfg_o.parity_odd))
    else $error("bad uart byte format");
a_uart_dir_decode: assert property (
    !engine_reset_o |-> cfg_o.uart_mode == command_field_o[2] && (!cfg_o.uart_mode
    || (cfg_o.rx_enable == command_field_o[1] && cfg_o.tx_enable == command_field_o[0])))
    else $error("uart direction decode wrong");
a_strobe_needs_enable: assert property (cmd_strobe_o |-> !engine_reset_o)
    else $error("command accepted while disabled");
a_strobe_one_cycle: assert property (cmd_strobe_o |=> !cmd_strobe_o)
    else $error("command strobe longer than one cycle");
a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
c_command: cover property (cmd_strobe_o);
c_irq: cover property ($rose(irq_o));
c_tx_write: cover property (tx_data_strobe_o);
c_rx_read: cover property (rx_data_read_o);
endmodule // luc_sva
bind luc_top luc_sva chk (.ref_clk_i, .rst_b_i, .clk_en_i, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .evt_i, .cfg_o,
    .engine_reset_o, .cmd_strobe_o, .command_field_o, .irq_o, .tx_data_strobe_o, .rx_data_read_o);
`default_nettype wire

// [testbench/luc_engine_model.sv]
// Purpose: behavioural serial engine on the far side of luc_top
// Assumes: a LIN command other than 000 runs DLY cycles, then reports completion; 000 aborts
// Notes: the bench adds events of its own through inj_i
`timescale 1ns/1ps
`default_nettype none
module luc_engine_model #(
    parameter int DLY = 20
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic cmd_strobe_i,
    input wire logic [2:0] command_i,
    input wire logic reset_i,
    input wire luc_pkg::luc_evt_s inj_i,
    output luc_pkg::luc_evt_s evt_o,
    output logic busy_o,
    output logic [7:0] rx_data_o
);
// --------------
// frame activity
// --------------
logic [7:0] cnt;
logic [2:0] op;
always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        cnt <= 8'h00;
        op <= 3'h0;
        rx_data_o <= 8'h5A;
    end else begin
        rx_data_o <= ~rx_data_o + 8'h01;
        if (reset_i || inj_i.errs != 8'h00 || (cmd_strobe_i && command_i == 3'h0)) begin
            cnt <= 8'h00;
        end else if (cmd_strobe_i && !command_i[2]) begin
            cnt <= 8'(DLY);
            op <= command_i;
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end
end
assign busy_o = cnt != 8'h00;
always_comb begin
    evt_o = inj_i;
    if (cnt == 8'h01) begin
        evt_o.header_done = op == 3'h1;
        evt_o.rx_done = op == 3'h2;
        evt_o.tx_done = op == 3'h3;
    end
end
endmodule // luc_engine_model
`default_nettype wire

// [testbench/luc_top_test.sv]
// Purpose: self-checking bench of luc_top
// Assumes: engine model drives the event side; clk_en_i held high
// Notes: random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
module luc_top_test;
localparam logic [7:0] CT = luc_pkg::IDX_CONTROL;
localparam logic [7:0] ST = luc_pkg::IDX_STATUS;
localparam logic [7:0] IE = luc_pkg::IDX_IRQ_EN;
localparam logic [7:0] ER = luc_pkg::IDX_ERRORS;
localparam logic [7:0] DT = luc_pkg::IDX_DATA;
logic ref_clk, rst_b, awvalid, awready, wvalid, wready, bvalid, bready;
logic arvalid, arready, rvalid, rready, busy, ver, erst, cstb, txs, rxr, irq;
logic [luc_pkg::ADDR_W-1:0] awaddr, araddr;
logic [31:0] wdata, rdata, d;
logic [3:0] wstrb;
logic [1:0] bresp, rresp, r;
logic [5:0] hid;
logic [7:0] rxd, txd, c, v;
logic [2:0] cmdf;
luc_pkg::luc_evt_s evt, inj, e;
luc_pkg::luc_cfg_s cfg;
int err_total, samples_checked, b;
luc_top dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .clk_en_i(1'b1), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .evt_i(evt), .engine_busy_i(busy), .header_id_i(hid),
    .rx_data_i(rxd), .cfg_o(cfg), .protocol_version_select_o(ver), .engine_reset_o(erst),
    .cmd_strobe_o(cstb), .command_field_o(cmdf), .tx_data_o(txd), .tx_data_strobe_o(txs),
    .rx_data_read_o(rxr), .irq_o(irq));
luc_engine_model eng (.clk_i(ref_clk), .rst_b_i(rst_b), .cmd_strobe_i(cstb), .command_i(cmdf),
    .reset_i(erst), .inj_i(inj), .evt_o(evt), .busy_o(busy), .rx_data_o(rxd));
// -------------
// bench helpers
// -------------
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
        err_total++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] ix, input logic [7:0] val);
    logic a, w;
    @(posedge ref_clk);
    awaddr <= luc_pkg::ADDR_W'({ix, 2'b00});
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    a = 1'b1;
    w = 1'b1;
    while (a || w) begin
        @(posedge ref_clk);
        if (a && awready) begin
            a = 1'b0;
            awvalid <= 1'b0;
        end
        if (w && wready) begin
            w = 1'b0;
            wvalid <= 1'b0;
        end
    end
    while (!bvalid) @(posedge ref_clk);
    r = bresp;
    bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] ix);
    @(posedge ref_clk);
    araddr <= luc_pkg::ADDR_W'({ix, 2'b00});
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge ref_clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
endtask
task automatic inject(input luc_pkg::luc_evt_s ev);
    @(posedge ref_clk);
    inj <= ev;
    @(posedge ref_clk);
    inj <= '0;
endtask
function automatic logic [7:0] exp_cfg(input logic [7:0] cv);
    logic [1:0] f;
    f = cv[5:4];
    if (!cv[2]) return {1'b0, f != 2'h1, f == 2'h0 || f == 2'h3, f == 2'h3, 4'h0};
    return {1'b1, 2'h0, f == 2'h3, f == 2'h1 || f == 2'h2, f == 2'h2, cv[1], cv[0]};
endfunction
task automatic give_verdict;
    if (err_total == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// ---------
// sequences
// ---------
initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
end
initial begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    give_verdict();
end
initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {inj, hid} = '0;
    wstrb = 4'hF;
    void'($urandom(5963));
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 5; i++) begin
        rd(CT + i[7:0]);
        chk(d, 32'h0);
        chk(r, i == 4 ? luc_pkg::AXI_SLVERR : luc_pkg::AXI_OKAY);
    end
    wstrb <= 4'h0;
    wr(IE, 8'hFF);
    wstrb <= 4'hF;
    rd(IE);
    chk(d, 32'h0);
    v = 8'($urandom);
    wr(IE, v);
    rd(IE);
    chk(d, {28'h0, v[3:0]});
    for (int k = 0; k < 32; k++) begin
        if (k[4:2] inside {3'h1, 3'h2, 3'h3}) continue;
        c = {1'b0, 1'($urandom), k[1:0], 1'b1, k[4:2]};
        wr(CT, c);
        rd(CT);
        chk(d, {24'h0, c});
        chk(ver, c[6]);
        chk(cfg & (c[2] ? 8'h9F : 8'hF0), exp_cfg(c) & (c[2] ? 8'h9F : 8'hF0));
    end
    wr(IE, 8'h00);
    for (int j = 1; j < 4; j++) begin
        hid <= 6'(56 + $urandom % 8);
        b = j == 1 ? 2 : (j == 2 ? 0 : 1);
        wr(CT, {5'h01, j[2:0]});
        rd(ST);
        chk(d[4], 1'b1);
        do rd(ST); while (d[4]);
        chk(d[3:0], 4'(1 << b));
        if (j == 1) chk(d[7:5] & {1'b1, {2{hid >= 60}}}, {hid >= 60, hid[1:0] & {2{hid >= 60}}});
        chk(irq, 1'b0);
        wr(IE, 8'(1 << b));
        chk(irq, 1'b1);
        wr(ST, 8'(1 << b));
        chk(irq, 1'b0);
        wr(IE, 8'h00);
    end
    wr(IE, 8'h08);
    wr(CT, 8'h0B);
    wr(CT, 8'h09);
    wr(CT, 8'h08);
    rd(ER);
    chk(d, 32'hA0);
    chk(irq, 1'b1);
    wr(ST, 8'h08);
    rd(ER);
    chk(d, 32'h0);
    for (int i = 0; i < 8; i++) begin
        wr(CT, 8'h0A);
        e = '0;
        e.errs = 8'(1 << i);
        inject(e);
        rd(CT);
        chk(d[2:0], 3'h0);
        rd(ER);
        chk(d, 32'h1 << i);
        rd(ST);
        chk(d[3], 1'b1);
        wr(ST, 8'h08);
    end
    wr(CT, 8'h0F);
    e = '0;
    e.rx_done = 1'b1;
    e.tx_done = 1'b1;
    inject(e);
    wr(DT, v);
    chk(r, luc_pkg::AXI_OKAY);
    chk(txd, v);
    rd(ST);
    chk(d[1:0], 2'h0);
    e = '0;
    e.byte_overwrite = 1'b1;
    e.errs.framing_flag = 1'b1;
    inject(e);
    rd(ER);
    chk(d, 32'h30);
    rd(DT);
    rd(ST);
    chk(d[3], 1'b0);
    wr(CT, 8'hC8);
    do rd(CT); while (d[7]);
    chk(d, 32'h0);
    chk(erst, 1'b1);
    give_verdict();
end
endmodule // luc_top_test
`default_nettype wire
